// ---- src/smp_pkg.sv ----
`default_nettype none
package smp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 27;
  localparam int DQ_W = 16;
  localparam int LOW_ADDR_W = 16;
  localparam int NAND_W = 8;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;

  // ---------------------------------------------------------------
  // Flash density and highest used address bit
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {DEN_128M, DEN_256M, DEN_512M, DEN_1G, DEN_2G} smp_flash_den_t;
  localparam logic [4:0] TOP_BIT_128M = 5'h16;
  localparam logic [4:0] TOP_BIT_256M = 5'h17;
  localparam logic [4:0] TOP_BIT_512M = 5'h18;
  localparam logic [4:0] TOP_BIT_1G = 5'h19;
  localparam logic [4:0] TOP_BIT_2G = 5'h1a;

  // ---------------------------------------------------------------
  // Low-power SDRAM density, row and column widths
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SD_128M, SD_256M, SD_512M} smp_sdram_den_t;
  localparam logic [4:0] ROW_BITS_512M = 5'h0d;
  localparam logic [4:0] COL_BITS_512M = 5'h0a;
  localparam logic [4:0] ROW_BITS_256M = 5'h0d;
  localparam logic [4:0] COL_BITS_256M = 5'h09;
  localparam logic [4:0] ROW_BITS_128M = 5'h0c;
  localparam logic [4:0] COL_BITS_128M = 5'h09;

  // ---------------------------------------------------------------
  // Access kinds and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ACC_FLASH, ACC_SDRAM, ACC_NAND} smp_acc_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic addr_valid_n;
    logic sdram_sel;
    logic nand_sel;
    logic col_phase;
  } smp_pins_t;

  typedef struct packed {
    smp_acc_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
  } smp_wr_t;

  // Pin levels assumed while in reset: everything idle, die deselected
  localparam smp_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr_valid_n: 1'b1,
                                      sdram_sel: 1'b0, nand_sel: 1'b0, col_phase: 1'b0};

endpackage

`default_nettype wire

// ---- src/smp_addr_data_port.sv ----
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Flash address top bit follows density, 26 down to 22; unused upper bits ignored.
// - 512-Mbit SDRAM: row on bits 12..0, column on bits 9..0.
// - 256-Mbit SDRAM: row on bits 12..0, column on bits 8..0.
// - 128-Mbit SDRAM: row on bits 11..0, column on bits 8..0.
// - Data bus takes writes and commands from host, returns read data.
// - Data outputs float unless selected with output enable active.
// - Multiplexed mode: upper flash address bits 16 and up on separate bus.
// - Multiplexed read: low address first, host releases, device then drives data.
// - SDRAM accesses use all 16 shared bits for writes and reads.
// - NAND data uses only the low 8 bits of the shared bus; a mux-mode address still takes all 16.
// - Address is captured on the rising edge of address valid.
// - Chip enable high deselects: standby, data outputs floated.
module smp_addr_data_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic mux_mode,
  input wire smp_pkg::smp_flash_den_t flash_density,
  input wire smp_pkg::smp_sdram_den_t sdram_density,
  input wire smp_pkg::smp_pins_t pins,
  input wire logic [smp_pkg::ADDR_W-1:0] flash_addr_pin,
  input wire logic [smp_pkg::DQ_W-1:0] shared_addr_data_bus_i,
  output logic [smp_pkg::DQ_W-1:0] shared_addr_data_bus_o,
  output logic [1:0] shared_addr_data_bus_oe,
  output logic [smp_pkg::ADDR_W-1:0] acc_addr,
  output logic [smp_pkg::ROW_W-1:0] sdram_row,
  output logic [smp_pkg::COL_W-1:0] sdram_col,
  output logic wr_valid,
  output smp_pkg::smp_wr_t wr_beat,
  output logic rd_req,
  input wire logic [smp_pkg::DQ_W-1:0] rd_data,
  input wire logic rd_valid,
  output logic standby
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Mask with the low nbits set
  function automatic logic [smp_pkg::ADDR_W-1:0] low_mask(input logic [4:0] nbits);
    logic [smp_pkg::ADDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < smp_pkg::ADDR_W; i++) begin
      if (i < int'(nbits)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [4:0] top_bit(input smp_pkg::smp_flash_den_t d);
    case (d)
      smp_pkg::DEN_128M: return smp_pkg::TOP_BIT_128M;
      smp_pkg::DEN_256M: return smp_pkg::TOP_BIT_256M;
      smp_pkg::DEN_512M: return smp_pkg::TOP_BIT_512M;
      smp_pkg::DEN_1G: return smp_pkg::TOP_BIT_1G;
      default: return smp_pkg::TOP_BIT_2G;
    endcase
  endfunction

  function automatic logic [4:0] row_bits(input smp_pkg::smp_sdram_den_t d);
    case (d)
      smp_pkg::SD_128M: return smp_pkg::ROW_BITS_128M;
      smp_pkg::SD_256M: return smp_pkg::ROW_BITS_256M;
      default: return smp_pkg::ROW_BITS_512M;
    endcase
  endfunction

  function automatic logic [4:0] col_bits(input smp_pkg::smp_sdram_den_t d);
    case (d)
      smp_pkg::SD_128M: return smp_pkg::COL_BITS_128M;
      smp_pkg::SD_256M: return smp_pkg::COL_BITS_256M;
      default: return smp_pkg::COL_BITS_512M;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  smp_pkg::smp_pins_t pins_s1_r, pins_s2_r, pins_d_r;
  logic [smp_pkg::ADDR_W-1:0] addr_s1_r, addr_s2_r;
  logic [smp_pkg::DQ_W-1:0] dq_s1_r, dq_s2_r;
  logic mux_s1_r, mux_s2_r;

  // Two flops on every pin; strobe edges are read from stage two onward only
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_s1_r <= smp_pkg::PINS_IDLE;
      pins_s2_r <= smp_pkg::PINS_IDLE;
      pins_d_r <= smp_pkg::PINS_IDLE;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      mux_s1_r <= 1'b0;
      mux_s2_r <= 1'b0;
    end else begin
      pins_s1_r <= pins;
      pins_s2_r <= pins_s1_r;
      pins_d_r <= pins_s2_r;
      addr_s1_r <= flash_addr_pin;
      addr_s2_r <= addr_s1_r;
      dq_s1_r <= shared_addr_data_bus_i;
      dq_s2_r <= dq_s1_r;
      mux_s1_r <= mux_mode;
      mux_s2_r <= mux_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Decoded pin events
  // ---------------------------------------------------------------
  logic selected, out_en, adv_rise, we_rise;
  smp_pkg::smp_acc_t kind;
  logic [smp_pkg::ADDR_W-1:0] addr_raw;

  assign selected = ~pins_s2_r.ce_n;
  assign out_en = selected & ~pins_s2_r.oe_n;
  assign adv_rise = selected & pins_s2_r.addr_valid_n & ~pins_d_r.addr_valid_n;
  assign we_rise = selected & pins_s2_r.we_n & ~pins_d_r.we_n;
  assign kind = pins_s2_r.nand_sel ? smp_pkg::ACC_NAND :
                (pins_s2_r.sdram_sel ? smp_pkg::ACC_SDRAM : smp_pkg::ACC_FLASH);

  // Mux mode: low half from the shared bus, upper bits from the address pins
  assign addr_raw = mux_s2_r ?
                    {addr_s2_r[smp_pkg::ADDR_W-1:smp_pkg::LOW_ADDR_W], dq_s2_r} :
                    addr_s2_r;

  // ---------------------------------------------------------------
  // Bus phase tracking
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} smp_phase_t;
  smp_phase_t phase_r;

  // Address phase lasts while address valid is low; data phase follows capture
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= PH_IDLE;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          if (selected && !pins_s2_r.addr_valid_n) begin
            phase_r <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          if (!selected) begin
            phase_r <= PH_IDLE;
          end else if (adv_rise) begin
            phase_r <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (!selected) begin
            phase_r <= PH_IDLE;
          end else if (!pins_s2_r.addr_valid_n) begin
            phase_r <= PH_ADDR;
          end
        end
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address capture
  // ---------------------------------------------------------------
  // Bits above the density's top bit are not connected inside, so forced to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_addr <= '0;
    end else if (adv_rise) begin
      acc_addr <= addr_raw & low_mask(top_bit(flash_density) + 5'h01);
    end
  end

  // SDRAM row or column split, chosen by the column phase pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sdram_row <= '0;
      sdram_col <= '0;
    end else if (adv_rise && kind == smp_pkg::ACC_SDRAM) begin
      if (pins_s2_r.col_phase) begin
        sdram_col <= smp_pkg::COL_W'(addr_raw & low_mask(col_bits(sdram_density)));
      end else begin
        sdram_row <= smp_pkg::ROW_W'(addr_raw & low_mask(row_bits(sdram_density)));
      end
    end
  end

  // ---------------------------------------------------------------
  // Write beats
  // ---------------------------------------------------------------
  // Data is taken on the write strobe's rising edge; NAND keeps the low byte only
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_beat <= '0;
    end else begin
      wr_valid <= we_rise;
      if (we_rise) begin
        wr_beat.kind <= kind;
        wr_beat.addr <= acc_addr;
        if (kind == smp_pkg::ACC_NAND) begin
          wr_beat.data <= {{(smp_pkg::DQ_W-smp_pkg::NAND_W){1'b0}}, dq_s2_r[smp_pkg::NAND_W-1:0]};
        end else begin
          wr_beat.data <= dq_s2_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic drive_ok, rd_issued_r;

  // In mux mode the bus belongs to the host until its address has been taken
  assign drive_ok = out_en & (~mux_s2_r | phase_r == PH_DATA);

  // One fetch request per read; a new address or output disable rearms it
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_req <= 1'b0;
      rd_issued_r <= 1'b0;
    end else begin
      rd_req <= drive_ok & ~rd_issued_r & ~rd_req;
      if (!drive_ok || adv_rise) begin
        rd_issued_r <= 1'b0;
      end else if (rd_req) begin
        rd_issued_r <= 1'b1;
      end
    end
  end

  // Output data register; NAND reads return only the low byte
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_addr_data_bus_o <= '0;
    end else if (rd_valid) begin
      if (kind == smp_pkg::ACC_NAND) begin
        shared_addr_data_bus_o <= {{(smp_pkg::DQ_W-smp_pkg::NAND_W){1'b0}}, rd_data[smp_pkg::NAND_W-1:0]};
      end else begin
        shared_addr_data_bus_o <= rd_data;
      end
    end
  end

  // Byte-lane enables; upper lane stays floated for NAND
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_addr_data_bus_oe <= 2'h0;
    end else begin
      shared_addr_data_bus_oe[0] <= drive_ok;
      shared_addr_data_bus_oe[1] <= drive_ok & (kind != smp_pkg::ACC_NAND);
    end
  end

  // Standby follows deselection
  always_ff @(posedge clk) begin
    if (rst) begin
      standby <= 1'b1;
    end else begin
      standby <= ~selected;
    end
  end

endmodule

`default_nettype wire

// ---- test/smp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module smp_host_model (
  input wire logic clk,
  input wire logic [26:0] keep,
  input wire logic [15:0] bus_o,
  input wire logic [1:0] bus_oe,
  output smp_pkg::smp_pins_t pins,
  output logic [26:0] fa,
  output logic [15:0] bus_i
);
  logic [26:0] a_r = 27'h0;
  logic [15:0] drv_r = 16'h0;
  logic hd_r = 1'b0;
  initial pins = smp_pkg::PINS_IDLE;
  initial fa = 27'h0;
  initial bus_i = 16'h0;
  // Released lines flip each cycle, so a stale level never passes
  always @(posedge clk) begin
    fa <= (a_r & keep) | (~fa & ~keep);
    for (int i = 0; i < 16; i++) begin
      bus_i[i] <= bus_oe[i / 8] ? bus_o[i] : (hd_r ? drv_r[i] : ~bus_i[i]);
    end
  end
  // One access: address phase, then data phase; address valid held low 4 cycles, write or output strobe 14
  task automatic acc(input bit rd, input bit mux, input logic [26:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    pins.ce_n <= 1'b0;
    pins.addr_valid_n <= 1'b0;
    a_r <= a;
    drv_r <= mux ? a[15:0] : d;
    hd_r <= mux | ~rd;
    repeat (4) @(posedge clk);
    pins.addr_valid_n <= 1'b1;
    repeat (4) @(posedge clk);
    drv_r <= d;
    hd_r <= ~rd;
    pins.we_n <= rd;
    pins.oe_n <= ~rd;
    repeat (14) @(posedge clk);
    q = bus_i;
    pins.we_n <= 1'b1;
    pins.oe_n <= 1'b1;
    repeat (4) @(posedge clk);
    hd_r <= 1'b0;
    pins.ce_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- test/smp_addr_data_port_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module smp_addr_data_port_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic mux_mode,
  input wire smp_pkg::smp_flash_den_t flash_density,
  input wire smp_pkg::smp_pins_t pins,
  input wire logic [26:0] flash_addr_pin,
  input wire logic [15:0] shared_addr_data_bus_o,
  input wire logic [1:0] shared_addr_data_bus_oe,
  input wire logic [26:0] acc_addr,
  input wire logic wr_valid,
  input wire smp_pkg::smp_wr_t wr_beat,
  input wire logic rd_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic standby
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [26:0] keep;
  // Bits above the top address bit must read zero
  assign keep = 27'h7ffffff >> (3'h4 - flash_density);
  a_float_desel: assert property (pins.ce_n [*5] |-> shared_addr_data_bus_oe == 2'h0 && standby)
    else $error("bus driven while deselected");
  a_wake_sel: assert property (!pins.ce_n [*5] |-> !standby)
    else $error("standby while selected");
  a_float_oe_off: assert property (pins.oe_n [*5] |-> shared_addr_data_bus_oe == 2'h0)
    else $error("bus driven with output off");
  a_addr_quiet: assert property ((mux_mode && !pins.addr_valid_n) [*5] |-> shared_addr_data_bus_oe == 2'h0)
    else $error("bus driven in address phase");
  a_nand_lane: assert property (pins.nand_sel [*5] |-> !shared_addr_data_bus_oe[1])
    else $error("upper lane driven for nand");
  a_wr_strobe: assert property ($rose(pins.we_n) && !pins.ce_n |-> ##[2:4] wr_valid)
    else $error("write beat missing");
  a_addr_capture: assert property (!mux_mode && !pins.ce_n && $rose(pins.addr_valid_n) ##1
    $stable(flash_addr_pin & keep) [*3] |-> ##[0:2] acc_addr == (flash_addr_pin & keep))
    else $error("address not captured");
  a_rd_follows: assert property ($rose(shared_addr_data_bus_oe[0]) |-> rd_req)
    else $error("read request missing");
  a_rd_out: assert property (rd_valid && !pins.nand_sel |=> shared_addr_data_bus_o == $past(rd_data))
    else $error("read data not driven");
  c_mux_read: cover property (mux_mode && rd_req);
  c_nand_wr: cover property (wr_valid && wr_beat.kind == smp_pkg::ACC_NAND);
  c_sdram_wr: cover property (wr_valid && wr_beat.kind == smp_pkg::ACC_SDRAM);
endmodule
bind smp_addr_data_port smp_addr_data_port_chk u_chk (.clk, .rst, .mux_mode, .flash_density, .pins,
  .flash_addr_pin, .shared_addr_data_bus_o, .shared_addr_data_bus_oe, .acc_addr, .wr_valid, .wr_beat,
  .rd_req, .rd_data, .rd_valid, .standby);
`default_nettype wire

// ---- test/smp_addr_data_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module smp_addr_data_port_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mux_mode = 1'b0;
  smp_pkg::smp_flash_den_t flash_density = smp_pkg::DEN_128M;
  smp_pkg::smp_sdram_den_t sdram_density = smp_pkg::SD_128M;
  smp_pkg::smp_pins_t pins;
  smp_pkg::smp_wr_t wr_beat;
  logic [26:0] fa, acc_addr, keep, a;
  logic [15:0] bus_i, bus_o, q, d;
  logic [15:0] rd_data = 16'h0;
  logic [1:0] oe;
  logic [12:0] row;
  logic [9:0] col;
  logic wr_valid, rd_req, standby;
  logic rd_valid = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  // Host leaves flash pins below bit 16 floating in multiplexed mode
  assign keep = (27'h7ffffff >> (3'h4 - flash_density)) & (mux_mode ? 27'h7ff0000 : 27'h7ffffff);
  smp_addr_data_port dut (.clk, .rst, .mux_mode, .flash_density, .sdram_density, .pins,
    .flash_addr_pin(fa), .shared_addr_data_bus_i(bus_i), .shared_addr_data_bus_o(bus_o),
    .shared_addr_data_bus_oe(oe), .acc_addr, .sdram_row(row), .sdram_col(col), .wr_valid,
    .wr_beat, .rd_req, .rd_data, .rd_valid, .standby);
  smp_host_model host (.clk, .keep, .bus_o, .bus_oe(oe), .pins, .fa, .bus_i);
  // Memory side: content is the inverted address, answered next cycle
  always @(posedge clk) begin
    rd_valid <= (rd_req === 1'b1);
    rd_data <= ~acc_addr[15:0];
  end
  task automatic chk(input string nm, input logic [26:0] exp, input logic [26:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Flash address bits kept for a density code
  function automatic logic [26:0] flash_mask(input int n);
    return 27'h7ffffff >> (4 - n);
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, well above the roughly 1100 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    d = 16'($urandom(61444));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("standby", 27'h1, standby);
    chk("oe", 27'h0, oe);
    for (int m = 0; m < 2; m++) begin
      for (int n = 0; n < 5; n++) begin
        @(posedge clk);
        mux_mode <= m[0];
        flash_density <= smp_pkg::smp_flash_den_t'(n);
        repeat (4) @(posedge clk);
        a = 27'($urandom);
        d = 16'($urandom);
        host.acc(1'b0, m[0], a, d, q);
        chk("acc_addr", a & flash_mask(n), acc_addr);
        chk("wr_addr", a & flash_mask(n), wr_beat.addr);
        chk("wr_data", d, wr_beat.data);
        host.acc(1'b1, m[0], a, 16'h0, q);
        chk("rd_data", 16'(~a[15:0]), q);
      end
    end
    mux_mode <= 1'b0;
    host.pins.sdram_sel <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      sdram_density <= smp_pkg::smp_sdram_den_t'(n);
      for (int c = 0; c < 2; c++) begin
        host.pins.col_phase <= c[0];
        a = 27'($urandom);
        d = 16'($urandom);
        host.acc(1'b0, 1'b0, a, d, q);
        if (c == 1) chk("col", a & (n == 2 ? 27'h3ff : 27'h1ff), col);
        else chk("row", a & (n == 0 ? 27'hfff : 27'h1fff), row);
        chk("kind", smp_pkg::ACC_SDRAM, wr_beat.kind);
        chk("sd_data", d, wr_beat.data);
      end
    end
    host.pins.sdram_sel <= 1'b0;
    host.pins.nand_sel <= 1'b1;
    mux_mode <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 16'hff00 : 16'($urandom);
      host.acc(1'b0, 1'b1, a, d, q);
      chk("nand_wr", {8'h00, d[7:0]}, wr_beat.data);
      host.acc(1'b1, 1'b1, a, 16'h0, q);
      chk("nand_rd", 8'(~a[7:0]), q[7:0]);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
